// ### logic/usr4_shift_register.sv
// Behaviour
// - four edge-triggered bits; shift, load, hold
// - master reset low clears outputs immediately
// - two mode selects alone pick operation
// - inputs sampled only at rising edge
// - both selects low holds contents unchanged
// - shift right: serial into bit 0
// - shift left: serial into bit 3
// - both selects high loads parallel word
`timescale 1ns/1ns
module usr4_shift_register
    import usr4_pkg::*;
#(
    parameter int WIDTH = USR4_WIDTH
) (
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic master_reset_n,
    // operation select
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    // serial and parallel data
    input wire logic right_serial_in,
    input wire logic left_serial_in,
    input wire logic [WIDTH-1:0] parallel_in,
    // register contents
    output logic [WIDTH-1:0] reg_out,
    // captured-word stream
    output logic capture_ready,
    output logic [WIDTH-1:0] word_out,
    output logic word_valid,
    input wire logic word_ready
);

    // register state and its next value
    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;
    // two-entry buffer state
    logic [WIDTH-1:0] head_reg;
    logic [WIDTH-1:0] head_next;
    logic [WIDTH-1:0] tail_reg;
    logic [WIDTH-1:0] tail_next;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic ready_reg;
    logic ready_next;
    // head-valid flag, kept in its own flip-flop so the port is registered
    logic valid_reg;
    logic valid_next;
    // decoded operation and handshake terms
    usr4_op_t op;
    logic push;
    logic pop;
    logic accept;
    // clear value sized to the register width
    localparam logic [WIDTH-1:0] CLEAR_WORD = WIDTH'(USR4_CLEAR_VALUE);

    // operation comes only from the two selects
    assign op = usr4_op_t'({mode_select_high, mode_select_low});

    // next register contents per operation
    always_comb begin
        data_next = data_reg;
        case (op)
            // hold: serial and parallel data ignored
            USR4_OP_HOLD: begin
                data_next = data_reg;
            end
            // shift toward bit 3, serial into bit 0
            USR4_OP_RIGHT: begin
                data_next = {data_reg[WIDTH-2:0], right_serial_in};
            end
            // shift toward bit 0, serial into bit 3
            USR4_OP_LEFT: begin
                data_next = {left_serial_in, data_reg[WIDTH-1:1]};
            end
            // parallel load of the whole word
            USR4_OP_LOAD: begin
                data_next = parallel_in;
            end
            default: begin
                data_next = data_reg;
            end
        endcase
    end

    // storage: async clear from master reset, sampling on rising edge
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            data_reg <= CLEAR_WORD;
        end else if (reset) begin
            data_reg <= CLEAR_WORD;
        end else begin
            data_reg <= data_next;
        end
    end

    // outputs are the stored bits themselves
    assign reg_out = data_reg;

    // buffer handshake terms: every non-hold edge offers a new word
    assign push = (op != USR4_OP_HOLD);
    assign pop = (count_reg != USR4_BUF_EMPTY) && word_ready;
    assign accept = push && ((count_reg != USR4_BUF_FULL) || pop);

    // buffer next state
    always_comb begin
        head_next = head_reg;
        tail_next = tail_reg;
        count_next = count_reg;
        case (count_reg)
            // empty: new word becomes head
            2'h0: begin
                if (accept) begin
                    head_next = data_next;
                    count_next = 2'h1;
                end
            end
            // one word: replace, append or drain
            2'h1: begin
                if (accept && pop) begin
                    head_next = data_next;
                end else if (accept) begin
                    tail_next = data_next;
                    count_next = 2'h2;
                end else if (pop) begin
                    count_next = 2'h0;
                end
            end
            // full: advance tail, refill behind it
            2'h2: begin
                if (pop) begin
                    head_next = tail_reg;
                    if (accept) begin
                        tail_next = data_next;
                    end else begin
                        count_next = 2'h1;
                    end
                end
            end
            default: begin
                count_next = USR4_BUF_EMPTY;
            end
        endcase
        ready_next = (count_next != USR4_BUF_FULL);
        valid_next = (count_next != USR4_BUF_EMPTY);
    end

    // buffer registers
    always_ff @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            head_reg <= CLEAR_WORD;
            tail_reg <= CLEAR_WORD;
            count_reg <= USR4_BUF_EMPTY;
            ready_reg <= 1'b1;
            valid_reg <= 1'b0;
        end else if (reset) begin
            head_reg <= CLEAR_WORD;
            tail_reg <= CLEAR_WORD;
            count_reg <= USR4_BUF_EMPTY;
            ready_reg <= 1'b1;
            valid_reg <= 1'b0;
        end else begin
            head_reg <= head_next;
            tail_reg <= tail_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
            valid_reg <= valid_next;
        end
    end

    // stream outputs straight from flip-flops
    assign word_out = head_reg;
    assign word_valid = valid_reg;
    assign capture_ready = ready_reg;

    // checks
    a_reset_clears_q: assert property (@(posedge clk)
        !master_reset_n |-> (reg_out == USR4_CLEAR_VALUE))
        else $error("master reset did not clear outputs");
    a_hold_keeps_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (op == USR4_OP_HOLD) ##1 (master_reset_n && !reset) |-> $stable(reg_out))
        else $error("hold changed the register");
    a_right_shift_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (op == USR4_OP_RIGHT) ##1 (master_reset_n && !reset) |->
        reg_out == {$past(reg_out[WIDTH-2:0]), $past(right_serial_in)})
        else $error("shift right wrong");
    a_left_shift_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (op == USR4_OP_LEFT) ##1 (master_reset_n && !reset) |->
        reg_out == {$past(left_serial_in), $past(reg_out[WIDTH-1:1])})
        else $error("shift left wrong");
    a_parallel_load_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (op == USR4_OP_LOAD) ##1 (master_reset_n && !reset) |->
        reg_out == $past(parallel_in))
        else $error("parallel load wrong");
    a_mode_decides_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (!mode_select_high && !mode_select_low) [*2] ##1 (master_reset_n && !reset)
        |-> reg_out == $past(reg_out, 2))
        else $error("register moved under hold selects");
    a_edge_sampling_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (master_reset_n && !reset) |=> (reg_out == $past(data_next)))
        else $error("register missed edge update");
    a_four_bit_store: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (op == USR4_OP_LOAD) ##1 (op == USR4_OP_HOLD) [*3] ##1 (master_reset_n && !reset)
        |-> reg_out == $past(parallel_in, 4))
        else $error("stored word lost");
    a_output_direct_q: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        reg_out == data_reg)
        else $error("outputs differ from stored bits");
    a_stall_holds_word: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        (word_valid && !word_ready) |=> (word_valid && $stable(word_out)))
        else $error("stalled word changed");
    a_buffer_never_over: assert property (@(posedge clk)
        disable iff (!master_reset_n || reset)
        count_reg <= USR4_BUF_FULL)
        else $error("buffer count overflow");

endmodule : usr4_shift_register

// ### common/usr4_pkg.sv
package usr4_pkg;
    // register width and reset contents
    localparam int USR4_WIDTH = 4;
    localparam logic [3:0] USR4_CLEAR_VALUE = 4'h0;
    // buffer depth limit, number of words held
    localparam logic [1:0] USR4_BUF_FULL = 2'h2;
    localparam logic [1:0] USR4_BUF_EMPTY = 2'h0;
    // operation codes, {mode_select_high, mode_select_low}
    typedef enum logic [1:0] {
        USR4_OP_HOLD  = 2'h0,
        USR4_OP_RIGHT = 2'h1,
        USR4_OP_LEFT  = 2'h2,
        USR4_OP_LOAD  = 2'h3
    } usr4_op_t;
endpackage : usr4_pkg

// ### sim/usr4_drive_model.sv
`timescale 1ns/1ns
module usr4_drive_model
    import usr4_pkg::*;
(
    // requests from the bench
    input wire logic [1:0] op_req,
    input wire logic rsi_req,
    input wire logic lsi_req,
    input wire logic [3:0] par_req,
    // buffer state from the register
    input wire logic capture_ready,
    // pins of the register
    output logic mode_select_low,
    output logic mode_select_high,
    output logic right_serial_in,
    output logic left_serial_in,
    output logic [3:0] parallel_in
);
    // hold while the buffer is full, so that no captured word is lost
    always_comb begin
        {mode_select_high, mode_select_low} = capture_ready ? op_req : USR4_OP_HOLD;
    end
    // data lines pass straight through
    assign right_serial_in = rsi_req;
    assign left_serial_in = lsi_req;
    assign parallel_in = par_req;
endmodule : usr4_drive_model

// ### sim/usr4_shift_register_tb_top.sv
`timescale 1ns/1ns
module usr4_shift_register_tb_top;
    import usr4_pkg::*;
    // one table row: request and expected contents
    typedef struct packed {
        logic [1:0] op; logic rsi; logic lsi; logic [3:0] par; logic [3:0] q;
    } usr4_row_t;
    usr4_row_t rows [8] = '{'{2'h3, 1'h0, 1'h0, 4'hA, 4'hA}, '{2'h1, 1'h1, 1'h0, 4'h0, 4'h5},
        '{2'h1, 1'h0, 1'h1, 4'hF, 4'hA}, '{2'h2, 1'h0, 1'h1, 4'h0, 4'hD},
        '{2'h2, 1'h1, 1'h0, 4'hF, 4'h6}, '{2'h0, 1'h1, 1'h1, 4'hF, 4'h6},
        '{2'h3, 1'h1, 1'h1, 4'hC, 4'hC}, '{2'h0, 1'h1, 1'h1, 4'h3, 4'hC}};
    logic clk = 1'b0, reset = 1'b1, master_reset_n = 1'b1, word_ready = 1'b1;
    logic [1:0] op_req = 2'h0;
    logic rsi_req = 1'b0, lsi_req = 1'b0;
    logic [3:0] par_req = 4'h0;
    logic msl, msh, rsi, lsi, capture_ready, word_valid;
    logic [3:0] par, reg_out, word_out;
    int num_errors = 0, checks_done = 0;
    // far-side driving logic
    usr4_drive_model u_drv (.op_req(op_req), .rsi_req(rsi_req), .lsi_req(lsi_req),
        .par_req(par_req), .capture_ready(capture_ready), .mode_select_low(msl),
        .mode_select_high(msh), .right_serial_in(rsi), .left_serial_in(lsi), .parallel_in(par));
    usr4_shift_register u_dut (.clk(clk), .reset(reset), .master_reset_n(master_reset_n),
        .mode_select_low(msl), .mode_select_high(msh), .right_serial_in(rsi),
        .left_serial_in(lsi), .parallel_in(par), .reg_out(reg_out),
        .capture_ready(capture_ready), .word_out(word_out), .word_valid(word_valid),
        .word_ready(word_ready));
    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end
    // compare a word
    task chk_word(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    // compare a flag
    task chk_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    // request one operation, launched at a rising edge
    task drive(input logic [1:0] o, input logic r, input logic l, input logic [3:0] p);
        op_req <= o;
        rsi_req <= r;
        lsi_req <= l;
        par_req <= p;
    endtask : drive
    // report and stop
    task end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk_word(reg_out, 4'h0);
        chk_flag(capture_ready, 1'b1);
        // table rows, one operation per edge, receiver always ready
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk);
            if (i < 8) drive(rows[i].op, rows[i].rsi, rows[i].lsi, rows[i].par);
            else drive(2'h0, 1'h0, 1'h0, 4'h0);
            @(negedge clk);
            if (i > 0) begin
                chk_word(reg_out, rows[i-1].q);
                chk_flag(word_valid, rows[i-1].op != 2'h0);
                if (rows[i-1].op != 2'h0) chk_word(word_out, rows[i-1].q);
            end
        end
        // fill the buffer with the receiver stalled, then drain it
        @(posedge clk) word_ready <= 1'b0;
        drive(2'h3, 1'h0, 1'h0, 4'h1);
        @(posedge clk) drive(2'h3, 1'h0, 1'h0, 4'h2);
        @(posedge clk) drive(2'h3, 1'h0, 1'h0, 4'h3);
        repeat (2) @(posedge clk);
        word_ready <= 1'b1;
        drive(2'h0, 1'h0, 1'h0, 4'h3);
        @(negedge clk);
        chk_flag(capture_ready, 1'b0);
        chk_word(reg_out, 4'h2);
        chk_word(word_out, 4'h1);
        @(negedge clk);
        chk_word(word_out, 4'h2);
        @(negedge clk);
        chk_flag(word_valid, 1'b0);
        // inputs changed between edges do nothing until the edge
        par_req = 4'hF;
        op_req = 2'h3;
        #5 chk_word(reg_out, 4'h2);
        // master reset clears at once, without an edge
        master_reset_n = 1'b0;
        #1 chk_word(reg_out, 4'h0);
        @(negedge clk);
        chk_word(reg_out, 4'h0);
        @(posedge clk) master_reset_n <= 1'b1;
        @(negedge clk);
        chk_word(reg_out, 4'h0);
        @(negedge clk);
        chk_word(reg_out, 4'hF);
        // synchronous reset mid-run
        @(posedge clk) reset <= 1'b1;
        drive(2'h0, 1'h0, 1'h0, 4'h0);
        @(posedge clk) reset <= 1'b0;
        @(negedge clk);
        chk_word(reg_out, 4'h0);
        chk_flag(word_valid, 1'b0);
        end_sim();
    end
endmodule : usr4_shift_register_tb_top
